// ### bench/sfd_partner.sv
// Model of another channel that shares the fault line
`timescale 1ns/1ps
module sfd_partner (
  // Clock and command
  input  wire logic        sys_clk_in,
  input  wire logic        fault_in,
  input  wire logic [15:0] hold_in,
  // Wired line
  input  wire logic        dut_oe_in,
  output logic             line_out
);
  logic [15:0] cnt = 16'h0000;
  always @(posedge sys_clk_in) begin
    if (fault_in)
      cnt <= hold_in;
    else if (cnt != 16'h0000)
      cnt <= cnt - 16'h0001;
  end
  assign line_out = ~(dut_oe_in | (cnt != 16'h0000));
endmodule

// ### bench/sfd_props.sv
// Port assertions of the sequencer and their bind
`timescale 1ns/1ps
module sfd_props
  import sfd_pkg::*;
(
  // Clock, reset and APB
  input wire logic        sys_clk_in,
  input wire logic        rst_n_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  // Pins
  input wire logic        control_pin_in,
  input wire logic        shared_fault_line_in,
  input wire logic        shared_fault_line_n_out,
  input wire logic        shared_fault_line_oe_out,
  input wire logic        supply_enable_out,
  input wire logic        alert_out_n
);
  logic [SFD_CTRL_W-1:0] ctrl_q;
  logic [15:0]           ton_q;
  logic [16:0]           hi_run;
  logic [3:0]            lo_run;
  logic                  wr_acc;
  assign wr_acc = psel_in & penable_in & pwrite_in & pready_out;
  // Shadow of what software wrote; line run lengths saturate
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_q <= SFD_CTRL_RST;
      ton_q  <= SFD_DLY_RST;
      hi_run <= 17'h00000;
      lo_run <= 4'h0;
    end else begin
      if (wr_acc && paddr_in == SFD_A_CTRL)
        ctrl_q <= pwdata_in[SFD_CTRL_W-1:0];
      if (wr_acc && paddr_in == SFD_A_TON)
        ton_q <= pwdata_in[15:0];
      hi_run <= !shared_fault_line_in ? 17'h00000 : hi_run + 17'(hi_run != 17'h1FFFF);
      lo_run <= shared_fault_line_in ? 4'h0 : lo_run + 4'(lo_run != 4'hF);
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  apb_one_wait_a: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("pready not one cycle after access");
  slverr_ready_a: assert property (pslverr_out |-> pready_out)
    else $error("pslverr outside ready");
  line_data_low_a: assert property (shared_fault_line_n_out == 1'b0)
    else $error("fault line driven high");
  alert_on_pull_a: assert property ($rose(shared_fault_line_oe_out) |-> ##[0:1] !alert_out_n)
    else $error("alert not low at fault");
  pull_needs_prop_a: assert property ($rose(shared_fault_line_oe_out) |-> ctrl_q[SFD_C_PROPAGATE])
    else $error("line pulled without propagation");
  resp_drop_a: assert property ($fell(shared_fault_line_in) && supply_enable_out
      && ctrl_q[SFD_C_RESPOND] && !ctrl_q[SFD_C_TOFF_FLT] && !shared_fault_line_oe_out
      |-> ##[1:5] !supply_enable_out)
    else $error("supply kept on after line fell");
  held_off_a: assert property (ctrl_q[SFD_C_RESPOND] && lo_run >= 4'h4 |-> !$rose(supply_enable_out))
    else $error("supply started while line low");
  ton_wait_a: assert property ($rose(supply_enable_out) && ctrl_q[SFD_C_RESPOND]
      |-> hi_run > {1'b0, ton_q})
    else $error("supply started before turn-on delay");
  off_req_a: assert property ($fell(control_pin_in) && !ctrl_q[SFD_C_SOFT_OFF]
      |-> ##[1:3] !supply_enable_out)
    else $error("supply kept on after off request");
  cover property ($rose(shared_fault_line_oe_out));
  cover property ($fell(shared_fault_line_in) && supply_enable_out);
  cover property (pslverr_out);
endmodule
bind sfd_sequencer sfd_props i_props (
  .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .control_pin_in(control_pin_in), .shared_fault_line_in(shared_fault_line_in),
  .shared_fault_line_n_out(shared_fault_line_n_out),
  .shared_fault_line_oe_out(shared_fault_line_oe_out),
  .supply_enable_out(supply_enable_out), .alert_out_n(alert_out_n)
);

// ### bench/testbench.sv
// Self-checking bench of the channel sequencer
`timescale 1ns/1ps
module testbench;
  import sfd_pkg::*;
  // ----------------
  // Signals
  // ----------------
  logic        sys_clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, cb;
  logic        pready, pslverr, err;
  logic        vin_low = 1'b0, ctl = 1'b0, chf = 1'b0, pf = 1'b0;
  logic [15:0] sensed = 16'h0000, ph = 16'h0000;
  logic        line, line_n, oe, sup, alert_n;
  int          err_total = 0, num_checks = 0, cycles = 0;
  always #2 sys_clk_in = ~sys_clk_in;
  sfd_sequencer i_dut (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready),
    .prdata_out(prdata), .pslverr_out(pslverr), .vin_below_off_in(vin_low),
    .control_pin_in(ctl), .sensed_output_in(sensed), .channel_fault_in(chf),
    .shared_fault_line_in(line), .shared_fault_line_n_out(line_n),
    .shared_fault_line_oe_out(oe), .supply_enable_out(sup), .alert_out_n(alert_n)
  );
  sfd_partner i_partner (
    .sys_clk_in(sys_clk_in), .fault_in(pf), .hold_in(ph), .dut_oe_in(oe), .line_out(line)
  );
  // ----------------
  // Helpers
  // ----------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask
  // Master holds the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (pready !== 1'b1 && n < 50);
    cb = w ? cb : prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(32'(n < 50), 1);
  endtask
  function automatic logic pick(input int s);
    return s == 0 ? sup : s == 1 ? oe : line;
  endfunction
  task automatic wfor(input int s, input logic v, input int mx, output int n);
    n = 0;
    while (pick(s) !== v && n < mx) begin
      @(posedge sys_clk_in);
      n++;
    end
    chk(pick(s), v);
  endtask
  function automatic logic [15:0] thr(input logic [15:0] v, input logic [15:0] f);
    return 16'((32'(v) * 32'(f)) >> SFD_FRAC_SH);
  endfunction
  task automatic setreq(input int k, input logic on);
    @(posedge sys_clk_in);
    if (k == 0)
      ctl <= on;
    else
      vin_low <= !on;
  endtask
  task automatic rd(input logic [7:0] a, input int b, input logic e);
    logic [31:0] keep;
    keep = cb;
    apb(1'b0, a, 32'h0);
    chk(cb[b], e);
    cb = keep;
  endtask
  // ----------------
  // Tests
  // ----------------
  logic [7:0]  ra[6] = '{SFD_A_CTRL, SFD_A_VCMD, SFD_A_FRAC, SFD_A_TON, SFD_A_TOFF, SFD_A_RETRY};
  logic [31:0] rx[6] = '{32'h0C, 32'h0, 32'h80, 32'h10, 32'h10, 32'h10};
  logic [15:0] fr[4] = '{16'h0080, 16'h0101, 16'h0100, 16'h0040};
  logic        dl[4] = '{1'b0, 1'b1, 1'b1, 1'b1};
  initial begin
    int n;
    logic x;
    logic [15:0] vc, ton, tof, rty;
    n = $urandom(32'hCC32);
    cyc(20);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk(cb, rx[i]);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk(cb, 32'h0);
    chk(32'(err), 32'h1);
    chk({sup, oe, alert_n, line_n}, 4'b0010);
    $display("test reset done");
    ton = 16'(6 + $urandom % 20);
    tof = 16'(6 + $urandom % 20);
    rty = 16'(6 + $urandom % 20);
    vc = 16'(16'h0100 + $urandom % 16'h0F00);
    fr[3] = 16'(16'h0020 + $urandom % 16'h00E0);
    apb(1'b1, SFD_A_TON, 32'(ton));
    apb(1'b1, SFD_A_TOFF, 32'(tof));
    apb(1'b1, SFD_A_RETRY, 32'(rty));
    apb(1'b1, SFD_A_VCMD, 32'(vc));
    apb(1'b1, SFD_A_CTRL, 32'h0D);
    setreq(0, 1'b1);
    wfor(0, 1'b1, ton + 20, n);
    for (int k = 0; k < 2; k++) begin
      setreq(k, 1'b0);
      wfor(0, 1'b0, 4, n);
      setreq(k, 1'b1);
      wfor(0, 1'b1, ton + 20, n);
    end
    apb(1'b1, SFD_A_CTRL, 32'h0C);
    wfor(0, 1'b0, 4, n);
    apb(1'b1, SFD_A_CTRL, 32'h0F);
    wfor(0, 1'b1, ton + 20, n);
    setreq(0, 1'b0);
    wfor(0, 1'b0, tof + 20, n);
    chk(32'(n > tof), 1);
    $display("test on_off done");
    apb(1'b1, SFD_A_CTRL, 32'h0D);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, SFD_A_FRAC, 32'(fr[i]));
      apb(1'b1, SFD_A_CLEAR, 32'h3F);
      setreq(0, 1'b0);
      wfor(0, 1'b0, tof + 20, n);
      sensed <= thr(vc, fr[i]) + 16'(dl[i]);
      x = dl[i] && fr[i] <= SFD_FRAC_ONE;
      setreq(0, 1'b1);
      cyc(4);
      chk({oe, alert_n}, {x, !x});
      sensed <= thr(vc, fr[i]);
      wfor(1, 1'b0, 4, n);
      wfor(0, 1'b1, ton + 20, n);
      chk(32'(n >= ton), 1);
    end
    rd(SFD_A_STATUS, SFD_S_DISCHG, 1'b1);
    apb(1'b1, SFD_A_CLEAR, 32'h01);
    rd(SFD_A_STATUS, SFD_S_DISCHG, 1'b0);
    chk({sup, oe, alert_n}, 3'b101);
    sensed <= 16'h0000;
    $display("test discharge done");
    ph <= 16'(20 + $urandom % 20);
    pf <= 1'b1;
    setreq(0, 1'b1);
    pf <= 1'b0;
    wfor(0, 1'b0, 6, n);
    rd(SFD_A_STATUS, SFD_S_LINE_IN, 1'b1);
    wfor(0, 1'b1, ton + 80, n);
    apb(1'b1, SFD_A_CTRL, 32'h1D);
    ph <= tof + 16'd20;
    pf <= 1'b1;
    setreq(0, 1'b1);
    pf <= 1'b0;
    wfor(0, 1'b0, tof + 20, n);
    chk(32'(n >= tof), 1);
    wfor(0, 1'b1, ton + tof + 80, n);
    apb(1'b1, SFD_A_CTRL, 32'h05);
    ph <= ton + 16'd60;
    pf <= 1'b1;
    setreq(0, 1'b0);
    pf <= 1'b0;
    setreq(0, 1'b1);
    wfor(0, 1'b1, ton + 20, n);
    chk(line, 1'b0);
    wfor(2, 1'b1, ton + 80, n);
    $display("test shared_line done");
    apb(1'b1, SFD_A_CTRL, 32'h2D);
    setreq(1, 1'b1);
    chf <= 1'b1;
    wfor(0, 1'b0, 4, n);
    wfor(1, 1'b1, 4, n);
    cyc(rty + 10);
    chk(oe, 1'b1);
    chf <= 1'b0;
    wfor(1, 1'b0, rty + 20, n);
    wfor(0, 1'b1, ton + rty + 40, n);
    apb(1'b1, SFD_A_CTRL, 32'h0D);
    chf <= 1'b1;
    wfor(1, 1'b1, 4, n);
    chf <= 1'b0;
    cyc(rty + 20);
    setreq(0, 1'b0);
    cyc(4);
    chk(oe, 1'b1);
    setreq(0, 1'b1);
    wfor(1, 1'b0, 6, n);
    wfor(0, 1'b1, ton + 20, n);
    apb(1'b1, SFD_A_CTRL, 32'h4D);
    chf <= 1'b1;
    cyc(4);
    chk({sup, oe}, 2'b10);
    chf <= 1'b0;
    $display("test channel_fault done");
    end_of_test();
  end
endmodule

// ### src/sfd_delay_timer.sv
// Programmable one-shot delay counter on the device clock
`timescale 1ns/1ps
module sfd_delay_timer #(
  parameter int DLY_W = 16
) (
  // Clock and reset
  input  wire logic             sys_clk_in,
  input  wire logic             rst_n_in,
  // Control
  input  wire logic             start_in,
  input  wire logic [DLY_W-1:0] count_in,
  input  wire logic             abort_in,
  // Result
  output logic                  done_out
);

  if (DLY_W < 1 || DLY_W > 16) begin : g_chk
    $error("sfd_delay_timer: DLY_W must be 1..16");
  end

  typedef struct packed {
    logic             run;
    logic [DLY_W-1:0] cnt;
    logic             done;
  } sfd_tmr_t;

  sfd_tmr_t r;
  sfd_tmr_t next_r;

  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    if (abort_in) begin
      next_r.run = 1'b0;
    end else if (start_in) begin
      next_r.run = 1'b1;
      next_r.cnt = count_in;
    end else if (r.run) begin
      if (r.cnt == '0) begin
        next_r.run  = 1'b0;
        next_r.done = 1'b1;
      end else begin
        next_r.cnt = r.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign done_out = r.done;

endmodule

// ### src/sfd_pkg.sv
// Package: register map, field positions and reset values of the sequencer
package sfd_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SFD_A_CTRL   = 8'h00;
  localparam logic [7:0] SFD_A_VCMD   = 8'h04;
  localparam logic [7:0] SFD_A_FRAC   = 8'h08;
  localparam logic [7:0] SFD_A_TON    = 8'h0C;
  localparam logic [7:0] SFD_A_TOFF   = 8'h10;
  localparam logic [7:0] SFD_A_RETRY  = 8'h14;
  localparam logic [7:0] SFD_A_STATUS = 8'h18;
  localparam logic [7:0] SFD_A_CLEAR  = 8'h1C;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int SFD_C_OP_ON     = 0;
  localparam int SFD_C_SOFT_OFF  = 1;
  localparam int SFD_C_PROPAGATE = 2;
  localparam int SFD_C_RESPOND   = 3;
  localparam int SFD_C_TOFF_FLT  = 4;
  localparam int SFD_C_RETRY     = 5;
  localparam int SFD_C_IGNORE    = 6;
  localparam int SFD_CTRL_W      = 7;

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int SFD_S_DISCHG    = 0;
  localparam int SFD_S_CHAN      = 1;
  localparam int SFD_S_LINE_IN   = 2;
  localparam int SFD_S_SUPPLY    = 8;
  localparam int SFD_S_PULL      = 9;
  localparam int SFD_S_LINE_LVL  = 10;
  localparam int SFD_S_STATE     = 12;

  // ----------------------------------------------------------------
  // Reset values and fraction format (8 fraction bits, 0x0100 = 1.0)
  // ----------------------------------------------------------------
  localparam logic [SFD_CTRL_W-1:0] SFD_CTRL_RST = 7'h0C;
  localparam logic [15:0]           SFD_VCMD_RST = 16'h0000;
  localparam logic [15:0]           SFD_FRAC_RST = 16'h0080;
  localparam logic [15:0]           SFD_DLY_RST  = 16'h0010;
  localparam logic [15:0]           SFD_FRAC_ONE = 16'h0100;
  localparam int                    SFD_FRAC_SH  = 8;

  typedef enum logic [3:0] {
    SFD_OFF, SFD_DISCHG, SFD_HELD, SFD_TON, SFD_ON, SFD_TOFF,
    SFD_RETRY_WAIT, SFD_LATCH, SFD_LATCH_OFF
  } sfd_state_t;

endpackage

// ### src/sfd_sequencer.sv
// Channel on/off sequencer with discharge check and shared fault line
`timescale 1ns/1ps
module sfd_sequencer
  import sfd_pkg::*;
#(
  parameter int ADC_W    = 16,
  parameter int DLY_W    = 16,
  parameter int LINE_IDX = 0
) (
  // Clock and reset
  input  wire logic             sys_clk_in,
  input  wire logic             rst_n_in,
  // APB slave
  input  wire logic             psel_in,
  input  wire logic             penable_in,
  input  wire logic             pwrite_in,
  input  wire logic [7:0]       paddr_in,
  input  wire logic [31:0]      pwdata_in,
  output logic                  pready_out,
  output logic [31:0]           prdata_out,
  output logic                  pslverr_out,
  // Turn-on conditions and measurements
  input  wire logic             vin_below_off_in,
  input  wire logic             control_pin_in,
  input  wire logic [ADC_W-1:0] sensed_output_in,
  input  wire logic             channel_fault_in,
  // Shared fault line, open drain
  input  wire logic             shared_fault_line_in,
  output logic                  shared_fault_line_n_out,
  output logic                  shared_fault_line_oe_out,
  // Supply and alert
  output logic                  supply_enable_out,
  output logic                  alert_out_n
);

  if (ADC_W < 1 || ADC_W > 16 || LINE_IDX < 0 || LINE_IDX > 3) begin : g_chk
    $error("sfd_sequencer: ADC_W must be 1..16 and LINE_IDX 0..3");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    sfd_state_t              st;
    logic                    sync1;
    logic                    sync2;
    logic                    sync_prev;
    logic [SFD_CTRL_W-1:0]   ctrl;
    logic [15:0]             vcmd;
    logic [15:0]             frac;
    logic [DLY_W-1:0]        ton;
    logic [DLY_W-1:0]        toff;
    logic [DLY_W-1:0]        retry;
    logic                    dis_f;
    logic                    chan_f;
    logic [3:0]              line_f;
    logic                    toff_to_held;
    logic                    sup_en;
    logic                    pull;
    logic                    alert_n;
    logic                    pready;
    logic [31:0]             prdata;
    logic                    pslverr;
  } sfd_regs_t;

  sfd_regs_t r;
  sfd_regs_t next_r;

  logic             tmr_start;
  logic             tmr_abort;
  logic [DLY_W-1:0] tmr_count;
  logic             tmr_done;

  sfd_delay_timer #(
    .DLY_W (DLY_W)
  ) u_timer (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .start_in   (tmr_start),
    .count_in   (tmr_count),
    .abort_in   (tmr_abort),
    .done_out   (tmr_done)
  );

  // ----------------------------------------------------------------
  // Discharge threshold
  // ----------------------------------------------------------------
  logic [31:0] thr_prod;
  logic [23:0] thr_lvl;
  logic        above_thr;
  logic        chk_en;

  assign thr_prod  = 32'(r.vcmd) * 32'(r.frac);
  assign thr_lvl   = thr_prod[SFD_FRAC_SH +: 24];
  assign chk_en    = (r.frac <= SFD_FRAC_ONE);
  assign above_thr = chk_en && (24'(sensed_output_in) > thr_lvl);

  // ----------------------------------------------------------------
  // Sequencing and register access
  // ----------------------------------------------------------------
  logic on_req;
  logic line_lvl;
  logic line_fall;
  logic line_rise;
  logic respond;
  logic acc;
  logic [31:0] rd;

  always_comb begin
    next_r    = r;
    tmr_start = 1'b0;
    tmr_abort = 1'b0;
    tmr_count = r.ton;
    rd        = 32'h0000_0000;

    next_r.sync1     = shared_fault_line_in;
    next_r.sync2     = r.sync1;
    next_r.sync_prev = r.sync2;
    line_lvl  = r.sync2;
    line_fall = r.sync_prev && !r.sync2;
    line_rise = !r.sync_prev && r.sync2;
    respond   = r.ctrl[SFD_C_RESPOND];

    on_req = r.ctrl[SFD_C_OP_ON] && control_pin_in && !vin_below_off_in;

    // clear first, so a status set in the same cycle wins
    if (psel_in && penable_in && pwrite_in && r.pready && paddr_in == SFD_A_CLEAR) begin
      next_r.dis_f  = r.dis_f && !pwdata_in[SFD_S_DISCHG];
      next_r.chan_f = r.chan_f && !pwdata_in[SFD_S_CHAN];
      next_r.line_f = r.line_f & ~pwdata_in[SFD_S_LINE_IN +: 4];
    end

    case (r.st)
      SFD_OFF: begin
        next_r.sup_en = 1'b0;
        if (on_req) begin
          if (above_thr) begin
            next_r.dis_f = 1'b1;
            next_r.pull  = r.ctrl[SFD_C_PROPAGATE];
            next_r.st    = SFD_DISCHG;
          end else if (respond && !line_lvl) begin
            next_r.line_f[LINE_IDX] = 1'b1;
            next_r.st = SFD_HELD;
          end else begin
            tmr_start = 1'b1;
            next_r.st = SFD_TON;
          end
        end
      end
      SFD_DISCHG: begin
        if (!on_req) begin
          next_r.pull = 1'b0;
          next_r.st   = SFD_OFF;
        end else if (!above_thr) begin
          next_r.pull = 1'b0;
          next_r.st   = SFD_HELD;
        end
      end
      SFD_HELD: begin
        // Starts at the synchronised rise, or at once if the line is ignored or high
        if (!on_req) begin
          next_r.st = SFD_OFF;
        end else if (line_rise || line_lvl || !respond) begin
          tmr_start = 1'b1;
          next_r.st = SFD_TON;
        end
      end
      SFD_TON: begin
        if (!on_req) begin
          tmr_abort = 1'b1;
          next_r.st = SFD_OFF;
        end else if (respond && !line_lvl) begin
          tmr_abort = 1'b1;
          next_r.line_f[LINE_IDX] = 1'b1;
          next_r.st = SFD_HELD;
        end else if (tmr_done) begin
          // start the supply after turn-on delay
          next_r.sup_en = 1'b1;
          next_r.st     = SFD_ON;
        end
      end
      SFD_ON: begin
        if (channel_fault_in && !r.ctrl[SFD_C_IGNORE]) begin
          next_r.sup_en = 1'b0;
          next_r.chan_f = 1'b1;
          next_r.pull   = r.ctrl[SFD_C_PROPAGATE];
          tmr_count     = r.retry;
          tmr_start     = r.ctrl[SFD_C_RETRY];
          next_r.st     = r.ctrl[SFD_C_RETRY] ? SFD_RETRY_WAIT : SFD_LATCH;
        end else if (respond && (line_fall || !line_lvl)) begin
          next_r.line_f[LINE_IDX] = 1'b1;
          if (r.ctrl[SFD_C_TOFF_FLT]) begin
            tmr_count           = r.toff;
            tmr_start           = 1'b1;
            next_r.toff_to_held = 1'b1;
            next_r.st           = SFD_TOFF;
          end else begin
            next_r.sup_en = 1'b0;
            next_r.st     = SFD_HELD;
          end
        end else if (!on_req) begin
          if (r.ctrl[SFD_C_SOFT_OFF]) begin
            tmr_count           = r.toff;
            tmr_start           = 1'b1;
            next_r.toff_to_held = 1'b0;
            next_r.st           = SFD_TOFF;
          end else begin
            next_r.sup_en = 1'b0;
            next_r.st     = SFD_OFF;
          end
        end
      end
      SFD_TOFF: begin
        if (tmr_done) begin
          next_r.sup_en = 1'b0;
          next_r.st     = r.toff_to_held ? SFD_HELD : SFD_OFF;
        end
      end
      SFD_RETRY_WAIT: begin
        if (tmr_done) begin
          if (channel_fault_in) begin
            tmr_count = r.retry;
            tmr_start = 1'b1;
          end else begin
            next_r.pull = 1'b0;
            next_r.st   = SFD_HELD;
          end
        end
      end
      SFD_LATCH: begin
        if (!on_req) begin
          next_r.st = SFD_LATCH_OFF;
        end
      end
      SFD_LATCH_OFF: begin
        if (on_req) begin
          next_r.pull = 1'b0;
          next_r.st   = SFD_HELD;
        end
      end
      default: begin
        next_r.st = SFD_OFF;
      end
    endcase

    // ----------------------------------------------------------------
    // APB, one wait state
    // ----------------------------------------------------------------
    acc = psel_in && penable_in && !r.pready;
    next_r.pready  = acc;
    next_r.pslverr = 1'b0;
    if (acc) begin
      if (paddr_in == SFD_A_CTRL) begin
        rd = 32'(r.ctrl);
      end else if (paddr_in == SFD_A_VCMD) begin
        rd = 32'(r.vcmd);
      end else if (paddr_in == SFD_A_FRAC) begin
        rd = 32'(r.frac);
      end else if (paddr_in == SFD_A_TON) begin
        rd = 32'(r.ton);
      end else if (paddr_in == SFD_A_TOFF) begin
        rd = 32'(r.toff);
      end else if (paddr_in == SFD_A_RETRY) begin
        rd = 32'(r.retry);
      end else if (paddr_in == SFD_A_STATUS) begin
        rd[SFD_S_DISCHG]          = r.dis_f;
        rd[SFD_S_CHAN]            = r.chan_f;
        rd[SFD_S_LINE_IN +: 4]    = r.line_f;
        rd[SFD_S_SUPPLY]          = r.sup_en;
        rd[SFD_S_PULL]            = r.pull;
        rd[SFD_S_LINE_LVL]        = line_lvl;
        rd[SFD_S_STATE +: 4]      = r.st;
      end else if (paddr_in == SFD_A_CLEAR) begin
        rd = 32'h0000_0000;
      end else begin
        next_r.pslverr = 1'b1;
      end
      next_r.prdata = rd;
    end
    if (psel_in && penable_in && pwrite_in && r.pready) begin
      if (paddr_in == SFD_A_CTRL) begin
        next_r.ctrl = pwdata_in[SFD_CTRL_W-1:0];
      end else if (paddr_in == SFD_A_VCMD) begin
        next_r.vcmd = pwdata_in[15:0];
      end else if (paddr_in == SFD_A_FRAC) begin
        next_r.frac = pwdata_in[15:0];
      end else if (paddr_in == SFD_A_TON) begin
        next_r.ton = pwdata_in[DLY_W-1:0];
      end else if (paddr_in == SFD_A_TOFF) begin
        next_r.toff = pwdata_in[DLY_W-1:0];
      end else if (paddr_in == SFD_A_RETRY) begin
        next_r.retry = pwdata_in[DLY_W-1:0];
      end
    end

    next_r.alert_n = !(next_r.dis_f || next_r.chan_f || (|next_r.line_f));
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r         <= '0;
      r.st      <= SFD_OFF;
      r.sync1   <= 1'b1;
      r.sync2   <= 1'b1;
      r.sync_prev <= 1'b1;
      r.ctrl    <= SFD_CTRL_RST;
      r.vcmd    <= SFD_VCMD_RST;
      r.frac    <= SFD_FRAC_RST;
      r.ton     <= DLY_W'(SFD_DLY_RST);
      r.toff    <= DLY_W'(SFD_DLY_RST);
      r.retry   <= DLY_W'(SFD_DLY_RST);
      r.alert_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pready_out  = r.pready;
  assign prdata_out  = r.prdata;
  assign pslverr_out = r.pslverr;
  assign shared_fault_line_n_out  = 1'b0;
  assign shared_fault_line_oe_out = r.pull;
  assign supply_enable_out        = r.sup_en;
  assign alert_out_n              = r.alert_n;

endmodule
